// >>> rtl/csf_status.sv
// CPU status word, core control and interrupt bank
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/10ps

// Notes on behaviour
// - Bits 15, 14 show A/B overflow, read-only
// - Bits 13, 12 sticky saturation until cleared
// - Bit 10 ORs saturation; clearing clears both
// - Bit 9 high while repeat loop runs
// - Priority level is top bit over field
// - Top priority bit set blocks user interrupts
// - Nesting disable makes priority field read-only
module csf_status #(
  parameter int ADDR_W = 4
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  input  wire csf_pkg::csf_bus_req_t  bus,
  output logic [15:0]                 rdata,
  input  wire csf_pkg::csf_core_evt_t core_evt,
  output logic [3:0]                  cpu_priority_level,
  output logic                        user_irq_block,
  output logic                        irq
);

  if (ADDR_W != 4) begin : g_bad_addr
    $error("csf_status serves a four-bit word address only");
  end

  logic        acc_a_overflow;
  logic        acc_b_overflow;
  logic        acc_a_saturated;
  logic        acc_b_saturated;
  logic        any_acc_overflow;
  logic        any_acc_saturated;
  logic        loop_active;
  logic [2:0]  priority_low_field;
  logic        priority_top_bit;
  logic        nesting_disable;
  logic [3:0]  irq_enable;
  logic [3:0]  irq_status;
  logic [1:0]  sat_q;
  logic [1:0]  sat_set;
  logic [1:0]  sat_clr;
  logic [3:0]  evt_set;
  logic [3:0]  evt_clr;
  logic        wr_status;
  logic [15:0] cpu_status_word;
  logic [15:0] next_rdata;

  // Address decode
  function automatic logic hit(input logic [3:0] a,
                               input logic [3:0] off);
    hit = (a == off);
  endfunction

  assign wr_status = bus.wr && hit(bus.addr, csf_pkg::OFF_STATUS);

  // Overflow flags follow the datapath
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_a_overflow <= 1'b0;
      acc_b_overflow <= 1'b0;
    end else begin
      acc_a_overflow <= core_evt.ovf_a;
      acc_b_overflow <= core_evt.ovf_b;
    end
  end

  assign any_acc_overflow = acc_a_overflow | acc_b_overflow;

  // Saturation flags, clear-only from software
  assign sat_set = {core_evt.sat_b, core_evt.sat_a};
  assign sat_clr[0] = wr_status &&
    (!bus.wdata[csf_pkg::BIT_SAT_A] ||
     !bus.wdata[csf_pkg::BIT_ANY_SAT]);
  assign sat_clr[1] = wr_status &&
    (!bus.wdata[csf_pkg::BIT_SAT_B] ||
     !bus.wdata[csf_pkg::BIT_ANY_SAT]);

  csf_sticky #(
    .W (2)
  ) u_sat (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .set     (sat_set),
    .clr     (sat_clr),
    .q       (sat_q)
  );

  assign acc_a_saturated   = sat_q[0];
  assign acc_b_saturated   = sat_q[1];
  assign any_acc_saturated = acc_a_saturated | acc_b_saturated;

  // Repeat loop indicator
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      loop_active <= 1'b0;
    end else begin
      loop_active <= core_evt.loop_run;
    end
  end

  // Low priority field
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      priority_low_field <= csf_pkg::RST_PRIO;
    end else if (wr_status && !nesting_disable) begin
      priority_low_field <= bus.wdata[csf_pkg::BIT_PRIO_LO +: 3];
    end
  end

  // Core control and interrupt control one
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      priority_top_bit <= 1'b0;
      nesting_disable  <= 1'b0;
    end else if (bus.wr) begin
      if (hit(bus.addr, csf_pkg::OFF_CORE_CTRL)) begin
        priority_top_bit <= bus.wdata[csf_pkg::BIT_PRIO_TOP];
      end
      if (hit(bus.addr, csf_pkg::OFF_INT_CTRL1)) begin
        nesting_disable <= bus.wdata[csf_pkg::BIT_NEST_DIS];
      end
    end
  end

  // Values the priority registers take at this edge
  function automatic logic next_top();
    next_top = (bus.wr && hit(bus.addr, csf_pkg::OFF_CORE_CTRL)) ?
               bus.wdata[csf_pkg::BIT_PRIO_TOP] : priority_top_bit;
  endfunction

  function automatic logic [2:0] next_low();
    next_low = (wr_status && !nesting_disable) ?
               bus.wdata[csf_pkg::BIT_PRIO_LO +: 3] : priority_low_field;
  endfunction

  // Priority level and user interrupt block
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cpu_priority_level <= 4'h0;
      user_irq_block     <= 1'b0;
    end else begin
      cpu_priority_level <= {next_top(), next_low()};
      user_irq_block     <= next_top();
    end
  end

  // Event interrupts
  always_comb begin
    evt_set = csf_pkg::RST_EVT;
    evt_set[csf_pkg::EVT_SAT_A] = core_evt.sat_a;
    evt_set[csf_pkg::EVT_SAT_B] = core_evt.sat_b;
    evt_set[csf_pkg::EVT_OVF_A] = core_evt.ovf_a && !acc_a_overflow;
    evt_set[csf_pkg::EVT_OVF_B] = core_evt.ovf_b && !acc_b_overflow;
  end

  assign evt_clr = (bus.wr && hit(bus.addr, csf_pkg::OFF_IRQ_CLEAR)) ?
                   bus.wdata[3:0] : 4'h0;

  csf_sticky #(
    .W (csf_pkg::EVT_W)
  ) u_evt (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .set     (evt_set),
    .clr     (evt_clr),
    .q       (irq_status)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_enable <= csf_pkg::RST_EVT;
    end else if (bus.wr && hit(bus.addr, csf_pkg::OFF_IRQ_ENABLE)) begin
      irq_enable <= bus.wdata[3:0];
    end
  end

  assign irq = |(irq_status & irq_enable);

  // Status word image
  always_comb begin
    cpu_status_word = csf_pkg::RST_WORD;
    cpu_status_word[csf_pkg::BIT_OVF_A]   = acc_a_overflow;
    cpu_status_word[csf_pkg::BIT_OVF_B]   = acc_b_overflow;
    cpu_status_word[csf_pkg::BIT_SAT_A]   = acc_a_saturated;
    cpu_status_word[csf_pkg::BIT_SAT_B]   = acc_b_saturated;
    cpu_status_word[csf_pkg::BIT_ANY_OVF] = any_acc_overflow;
    cpu_status_word[csf_pkg::BIT_ANY_SAT] = any_acc_saturated;
    cpu_status_word[csf_pkg::BIT_LOOP]    = loop_active;
    cpu_status_word[csf_pkg::BIT_PRIO_LO +: 3] = priority_low_field;
  end

  // Read mux
  always_comb begin
    next_rdata = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        csf_pkg::OFF_STATUS:     next_rdata = cpu_status_word;
        csf_pkg::OFF_CORE_CTRL:
          next_rdata[csf_pkg::BIT_PRIO_TOP] = priority_top_bit;
        csf_pkg::OFF_INT_CTRL1:
          next_rdata[csf_pkg::BIT_NEST_DIS] = nesting_disable;
        csf_pkg::OFF_IRQ_STATUS: next_rdata[3:0] = irq_status;
        csf_pkg::OFF_IRQ_ENABLE: next_rdata[3:0] = irq_enable;
        default:                 next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  logic rd_status;
  assign rd_status = bus.rd && hit(bus.addr, csf_pkg::OFF_STATUS);

  a_ovf_follow: assert property (
    ##1 (acc_a_overflow == $past(core_evt.ovf_a)) &&
        (acc_b_overflow == $past(core_evt.ovf_b)))
    else $error("overflow flag does not follow datapath");

  a_ovf_read: assert property (
    rd_status |=> rdata[15:14] == $past({acc_a_overflow, acc_b_overflow}))
    else $error("overflow bits read wrong");

  a_sat_sticky: assert property (
    acc_a_saturated && !sat_clr[0] |=> acc_a_saturated)
    else $error("saturation flag A dropped without clear");

  a_sat_set_wins: assert property (
    core_evt.sat_b |=> acc_b_saturated)
    else $error("saturation event B lost");

  a_sab_clear: assert property (
    wr_status && !bus.wdata[10] && !core_evt.sat_a && !core_evt.sat_b
    |=> !any_acc_saturated && !acc_a_saturated && !acc_b_saturated)
    else $error("summary clear left saturation set");

  a_sab_read: assert property (
    rd_status |=> rdata[10] == $past(acc_a_saturated | acc_b_saturated))
    else $error("saturation summary read wrong");

  a_loop_read: assert property (
    rd_status |=> rdata[9] == $past(loop_active))
    else $error("loop bit read wrong");

  a_level_join: assert property (
    ##1 cpu_priority_level == {priority_top_bit, priority_low_field})
    else $error("priority level not joined correctly");

  a_user_block: assert property (
    ##1 user_irq_block == priority_top_bit)
    else $error("user interrupts not blocked by top bit");

  a_prio_locked: assert property (
    wr_status && nesting_disable |=> $stable(priority_low_field))
    else $error("priority field changed while locked");

  a_oab_read: assert property (
    rd_status |=> rdata[11] == $past(acc_a_overflow | acc_b_overflow))
    else $error("overflow summary read wrong");

  a_irq_level: assert property (
    core_evt.sat_a && irq_enable[csf_pkg::EVT_SAT_A] &&
    !(bus.wr && hit(bus.addr, csf_pkg::OFF_IRQ_ENABLE)) |=> irq)
    else $error("interrupt output wrong");

  a_sat_a_wins: assert property (
    core_evt.sat_a |=> acc_a_saturated)
    else $error("saturation event A lost");

  a_sat_b_sticky: assert property (
    acc_b_saturated && !sat_clr[1] |=> acc_b_saturated)
    else $error("saturation flag B dropped without clear");

  a_sat_a_clear: assert property (
    wr_status && !bus.wdata[csf_pkg::BIT_SAT_A] && !core_evt.sat_a
    |=> !acc_a_saturated)
    else $error("saturation flag A not cleared");

  a_sab_no_set: assert property (
    !any_acc_saturated && !core_evt.sat_a && !core_evt.sat_b
    |=> !any_acc_saturated)
    else $error("saturation summary set by software");

  a_loop_follow: assert property (
    ##1 loop_active == $past(core_evt.loop_run))
    else $error("loop flag does not follow core");

  a_top_write: assert property (
    bus.wr && hit(bus.addr, csf_pkg::OFF_CORE_CTRL)
    |=> priority_top_bit == $past(bus.wdata[csf_pkg::BIT_PRIO_TOP]))
    else $error("priority top bit write lost");

  a_top_read: assert property (
    bus.rd && hit(bus.addr, csf_pkg::OFF_CORE_CTRL)
    |=> rdata[csf_pkg::BIT_PRIO_TOP] == $past(priority_top_bit))
    else $error("priority top bit read wrong");

  a_prio_write: assert property (
    wr_status && !nesting_disable
    |=> priority_low_field == $past(bus.wdata[csf_pkg::BIT_PRIO_LO +: 3]))
    else $error("priority field write lost");

  a_prio_read: assert property (
    rd_status
    |=> rdata[csf_pkg::BIT_PRIO_LO +: 3] == $past(priority_low_field))
    else $error("priority field read wrong");

  a_nest_write: assert property (
    bus.wr && hit(bus.addr, csf_pkg::OFF_INT_CTRL1)
    |=> nesting_disable == $past(bus.wdata[csf_pkg::BIT_NEST_DIS]))
    else $error("nesting disable write lost");

  a_enable_write: assert property (
    bus.wr && hit(bus.addr, csf_pkg::OFF_IRQ_ENABLE)
    |=> irq_enable == $past(bus.wdata[3:0]))
    else $error("interrupt enable write lost");

  a_evt_clear: assert property (
    bus.wr && hit(bus.addr, csf_pkg::OFF_IRQ_CLEAR) &&
    bus.wdata[csf_pkg::EVT_SAT_A] && !core_evt.sat_a
    |=> !irq_status[csf_pkg::EVT_SAT_A])
    else $error("interrupt status not cleared");

  a_ovf_rise: assert property (
    core_evt.ovf_b && !acc_b_overflow
    |=> irq_status[csf_pkg::EVT_OVF_B])
    else $error("overflow B event lost");

  a_rdata_idle: assert property (
    !bus.rd |=> rdata == 16'h0000)
    else $error("read data outside read cycle");

  c_sat_clear: cover property (
    acc_a_saturated ##1 wr_status && !bus.wdata[10]);
  c_prio_lock: cover property (wr_status && nesting_disable);
  c_block: cover property (user_irq_block && irq);
  c_loop: cover property (loop_active && rd_status);
  c_ovf_event: cover property (irq_status[csf_pkg::EVT_OVF_A] && rd_status);

endmodule

// >>> rtl/csf_pkg.sv
// Constants and carrier types for the CPU status flag bank
package csf_pkg;

  // Register word offsets
  localparam logic [3:0] OFF_STATUS     = 4'h0;
  localparam logic [3:0] OFF_CORE_CTRL  = 4'h1;
  localparam logic [3:0] OFF_INT_CTRL1  = 4'h2;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h3;
  localparam logic [3:0] OFF_IRQ_CLEAR  = 4'h4;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'h5;

  // Status word field positions
  localparam int BIT_OVF_A     = 15;
  localparam int BIT_OVF_B     = 14;
  localparam int BIT_SAT_A     = 13;
  localparam int BIT_SAT_B     = 12;
  localparam int BIT_ANY_OVF   = 11;
  localparam int BIT_ANY_SAT   = 10;
  localparam int BIT_LOOP      = 9;
  localparam int BIT_PRIO_LO   = 5;
  localparam int PRIO_LO_W     = 3;

  // Core control and interrupt control one fields
  localparam int BIT_PRIO_TOP  = 3;
  localparam int BIT_NEST_DIS  = 15;

  // Event interrupt bits
  localparam int EVT_SAT_A     = 0;
  localparam int EVT_SAT_B     = 1;
  localparam int EVT_OVF_A     = 2;
  localparam int EVT_OVF_B     = 3;
  localparam int EVT_W         = 4;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0]  RST_PRIO = 3'h0;
  localparam logic [3:0]  RST_EVT  = 4'h0;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } csf_bus_req_t;

  typedef struct packed {
    logic ovf_a;
    logic ovf_b;
    logic sat_a;
    logic sat_b;
    logic loop_run;
  } csf_core_evt_t;

endpackage

// >>> rtl/csf_sticky.sv
// Sticky flag bank, set wins over clear
`timescale 1ns/10ps
module csf_sticky #(
  parameter int W = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);

  if (W < 1) begin : g_bad_w
    $error("csf_sticky needs W of at least one");
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= (q & ~clr) | set;
    end
  end

endmodule

// >>> test/cpu_status_flags_bench.sv
// Self-checking bench for the CPU status flag bank
`timescale 1ns/10ps
module cpu_status_flags_bench;
  logic                   clk_sys;
  logic                   rst_b;
  csf_pkg::csf_bus_req_t  bus;
  logic [15:0]            rdata;
  csf_pkg::csf_core_evt_t core_evt;
  logic [3:0]             cpu_priority_level;
  logic                   user_irq_block;
  logic                   irq;
  int                     bad_count;
  int                     checks;

  csf_status csf_status_i (
    .clk_sys            (clk_sys),
    .rst_b              (rst_b),
    .bus                (bus),
    .rdata              (rdata),
    .core_evt           (core_evt),
    .cpu_priority_level (cpu_priority_level),
    .user_irq_block     (user_irq_block),
    .irq                (irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask

  // One-cycle read strobe, data checked in the following cycle
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp, "read data");
  endtask

  // Single-cycle saturation pulse
  task automatic sat_pulse(input logic on_a);
    @(posedge clk_sys);
    core_evt.sat_a <= on_a;
    core_evt.sat_b <= ~on_a;
    @(posedge clk_sys);
    core_evt.sat_a <= 1'b0;
    core_evt.sat_b <= 1'b0;
  endtask

  task automatic outs(input logic [3:0] lvl, input logic blk,
                      input logic irq_exp);
    #1;
    chk({12'h000, cpu_priority_level}, {12'h000, lvl}, "priority level");
    chk({15'h0000, user_irq_block}, {15'h0000, blk}, "irq block");
    chk({15'h0000, irq}, {15'h0000, irq_exp}, "irq line");
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    bus       = '0;
    core_evt  = '0;
    rst_b     = 1'b0;
    bad_count = 0;
    checks    = 0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Reset values, unmapped places read zero
    for (int a = 0; a < 16; a++) begin
      if (a != 4) rd(a[3:0], 16'h0000);
    end
    outs(4'h0, 1'b0, 1'b0);
    $display("test reset done");

    // Overflow, combined overflow and loop flags
    @(posedge clk_sys);
    core_evt.ovf_a    <= 1'b1;
    core_evt.loop_run <= 1'b1;
    rd(4'h0, 16'h8a00);
    @(posedge clk_sys);
    core_evt.ovf_a    <= 1'b0;
    core_evt.ovf_b    <= 1'b1;
    core_evt.loop_run <= 1'b0;
    rd(4'h0, 16'h4800);
    wr(4'h0, 16'hfe00);
    @(posedge clk_sys);
    core_evt.ovf_b <= 1'b0;
    rd(4'h0, 16'h0000);
    rd(4'h3, 16'h000c);
    $display("test overflow done");

    // Sticky saturation and clear-only summary
    sat_pulse(1'b1);
    rd(4'h0, 16'h2400);
    rd(4'h3, 16'h000d);
    sat_pulse(1'b0);
    rd(4'h0, 16'h3400);
    wr(4'h0, 16'h1400);
    rd(4'h0, 16'h1400);
    sat_pulse(1'b1);
    wr(4'h0, 16'h3000);
    rd(4'h0, 16'h0000);
    $display("test saturation done");

    // Interrupt enable, mask and clear
    wr(4'h5, 16'h0001);
    outs(4'h0, 1'b0, 1'b1);
    wr(4'h5, 16'h0000);
    outs(4'h0, 1'b0, 1'b0);
    wr(4'h5, 16'h000f);
    outs(4'h0, 1'b0, 1'b1);
    wr(4'h4, 16'h000f);
    rd(4'h3, 16'h0000);
    rd(4'h5, 16'h000f);
    outs(4'h0, 1'b0, 1'b0);
    $display("test interrupt done");

    // Priority level, blocking and nesting lock
    wr(4'h0, 16'h34a0);
    outs(4'h5, 1'b0, 1'b0);
    wr(4'h1, 16'h0008);
    outs(4'hd, 1'b1, 1'b0);
    rd(4'h1, 16'h0008);
    wr(4'h2, 16'h8000);
    rd(4'h2, 16'h8000);
    wr(4'h0, 16'h3440);
    rd(4'h0, 16'h00a0);
    outs(4'hd, 1'b1, 1'b0);
    wr(4'h2, 16'h0000);
    wr(4'h0, 16'h3440);
    rd(4'h0, 16'h0040);
    wr(4'h1, 16'h0000);
    outs(4'h2, 1'b0, 1'b0);
    $display("test priority done");
    final_report();
  end
endmodule
